// [qenc_pkg.sv]
// constants and register map of the quadrature encoder counter
`default_nettype none
package qenc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock
   localparam int CLK_HZ = 250_000_000;

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses, one word each)
   localparam int         ADDR_W       = 5;
   localparam logic [4:0] OFF_CTRL     = 5'h00;
   localparam logic [4:0] OFF_FILTER   = 5'h04;
   localparam logic [4:0] OFF_POSITION = 5'h08;
   localparam logic [4:0] OFF_SPEED    = 5'h0c;
   localparam logic [4:0] OFF_STATUS   = 5'h10;

   // control word fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_X4_BIT     = 1;
   localparam int CTRL_INVERT_BIT = 2;
   localparam int CTRL_CLEAR_BIT  = 8;
   localparam int CTRL_ARM_BIT    = 9;

   // status word fields
   localparam int STAT_ARMED_BIT  = 0;
   localparam int STAT_LEVEL_LSB  = 1;
   localparam int STAT_ENABLE_BIT = 4;

   // values after reset
   localparam logic       CTRL_ENABLE_RESET = 1'h0;
   localparam logic [9:0] FILT_RESET        = 10'h000;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // input filter
   localparam int FILT_W           = 10;
   localparam int FILT_MAX         = 1000;
   localparam int FILT_UNIT_CYCLES = 16;
   localparam int DIV_W            = 14;
   localparam int RATE_LIMIT_HZ    = 25_000;
   localparam int MIN_GAP_CYCLES   = CLK_HZ / RATE_LIMIT_HZ;

   ////////////////////////////////////////////////////////////////////////////
   // speed measurement
   localparam int SPEED_GATE_MS     = 10;
   localparam int SPEED_GATE_CYCLES = (CLK_HZ / 1000) * SPEED_GATE_MS;
   localparam int SPEED_SCALE       = 60_000 / SPEED_GATE_MS;
   localparam int GATE_W            = 22;

endpackage
`default_nettype wire

// [qenc_sample_divider.sv]
// sample enable divider for the phase input filter
`timescale 1ns/10ps
`default_nettype none
module qenc_sample_divider (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // filter delay constant
   input  wire logic [qenc_pkg::FILT_W-1:0] filt_delay,
   // one-cycle sample pulse
   output logic                           sample_en
);

   typedef struct packed {
      logic [qenc_pkg::DIV_W-1:0] cnt;
      logic                       pulse;
      logic [qenc_pkg::DIV_W-1:0] gap;
      logic                       seen;
   } div_s;

   div_s                       st_reg;
   div_s                       st_next;
   logic [qenc_pkg::DIV_W-1:0] limit;

   always_comb begin
      st_next = st_reg;
      limit = qenc_pkg::DIV_W'(int'(filt_delay) * qenc_pkg::FILT_UNIT_CYCLES - 1);
      if (filt_delay == '0) begin
         st_next.cnt = '0;
         st_next.pulse = 1'b0;
      end else if (st_reg.cnt >= limit) begin
         st_next.cnt = '0;
         st_next.pulse = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 14'h0001;
         st_next.pulse = 1'b0;
      end
      // gap tracker, read only by the rate check
      if (st_reg.pulse) begin
         st_next.gap = 14'h0001;
      end else if (st_reg.gap != 14'h3fff) begin
         st_next.gap = st_reg.gap + 14'h0001;
      end
      if (int'(filt_delay) != qenc_pkg::FILT_MAX) begin
         st_next.seen = 1'b0;
      end else if (st_reg.pulse) begin
         st_next.seen = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sample_en = st_reg.pulse;

   a_rate_limit: assert property (@(posedge clk) disable iff (rst)
      st_reg.pulse && st_reg.seen |-> int'(st_reg.gap) >= qenc_pkg::MIN_GAP_CYCLES)
      else $error("sample rate above limit at maximum delay");

endmodule
`default_nettype wire

// [qenc_input_sampler.sv]
// synchroniser and digital filter for phase and index pins
`timescale 1ns/10ps
`default_nettype none
module qenc_input_sampler (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        rst,
   // raw pins: bit0 phase a, bit1 phase b, bit2 index
   input  wire logic [2:0]                  pin_raw,
   // filter control
   input  wire logic                        sample_en,
   input  wire logic [qenc_pkg::FILT_W-1:0] filt_delay,
   // conditioned levels
   output logic [2:0]                       level
);

   typedef struct packed {
      logic [2:0] sync1;
      logic [2:0] sync2;
      logic [2:0] last;
      logic [2:0] level;
   } smp_s;

   smp_s       st_reg;
   smp_s       st_next;
   logic [2:0] agree;

   always_comb begin
      st_next = st_reg;
      st_next.sync1 = pin_raw;
      st_next.sync2 = st_reg.sync1;
      agree = ~(st_reg.sync2 ^ st_reg.last);
      if (filt_delay == '0) begin
         st_next.level = st_reg.sync2;
         st_next.last = st_reg.sync2;
      end else if (sample_en) begin
         // a bit moves only after two equal slow samples
         st_next.level = (st_reg.level & ~agree) | (st_reg.sync2 & agree);
         st_next.last = st_reg.sync2;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level = st_reg.level;

   a_filter_bypass: assert property (@(posedge clk) disable iff (rst)
      // one extra cycle so the look-back never reaches into reset
      (filt_delay == '0) [*4] |-> level == $past(pin_raw, 3))
      else $error("bypassed filter does not follow pins");

   a_filter_hold: assert property (@(posedge clk) disable iff (rst)
      filt_delay != '0 && !sample_en |=> $stable(level))
      else $error("filtered level moved without sample pulse");

endmodule
`default_nettype wire

// [quadrature_encoder_counter.sv]
// quadrature encoder counter with axi4-lite register slave
//
// Summary of operation
// - two phase pins plus an index pin; counting works with index unused
// - only double and quadruple counting; no single-edge mode exists
// - quadruple mode counts every edge of both phases
// - unfiltered decoding keeps up with 5 MHz edge rates
// - count stays frozen until software sets enable
// - direction invert swaps up and down counting
// - filter delay slows sampling; maximum setting samples below 25 kHz
// - filter delay zero bypasses the filter completely
// - software clear command zeroes the position immediately
// - signed speed in counts per minute is provided
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module quadrature_encoder_counter #(
   parameter int SPEED_GATE_CYCLES = qenc_pkg::SPEED_GATE_CYCLES
) (
   // clock and reset
   input  wire logic                        REF_CLK,
   input  wire logic                        RESET,
   // encoder pins
   input  wire logic                        ENC_A,
   input  wire logic                        ENC_B,
   input  wire logic                        ENC_INDEX,
   // axi4-lite write address
   input  wire logic                        S_AXI_AWVALID,
   output logic                             S_AXI_AWREADY,
   input  wire logic [qenc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   // axi4-lite write data
   input  wire logic                        S_AXI_WVALID,
   output logic                             S_AXI_WREADY,
   input  wire logic [31:0]                 S_AXI_WDATA,
   input  wire logic [3:0]                  S_AXI_WSTRB,
   // axi4-lite write response
   output logic                             S_AXI_BVALID,
   input  wire logic                        S_AXI_BREADY,
   output logic [1:0]                       S_AXI_BRESP,
   // axi4-lite read address
   input  wire logic                        S_AXI_ARVALID,
   output logic                             S_AXI_ARREADY,
   input  wire logic [qenc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   // axi4-lite read data
   output logic                             S_AXI_RVALID,
   input  wire logic                        S_AXI_RREADY,
   output logic [31:0]                      S_AXI_RDATA,
   output logic [1:0]                       S_AXI_RRESP
);

   typedef struct packed {
      // bus slave
      logic                        aw_have;
      logic [qenc_pkg::ADDR_W-1:0] aw_addr;
      logic                        w_have;
      logic [31:0]                 w_data;
      logic [3:0]                  w_strb;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        rvalid;
      logic [31:0]                 rdata;
      logic [1:0]                  rresp;
      // control
      logic                        enable;
      logic                        x4;
      logic                        invert;
      logic                        armed;
      logic [qenc_pkg::FILT_W-1:0] filt_delay;
      // decoder
      logic                        a_prev;
      logic                        b_prev;
      logic                        i_prev;
      logic [31:0]                 position;
      // speed
      logic [31:0]                 snap;
      logic [31:0]                 speed;
      logic [qenc_pkg::GATE_W-1:0] gate;
   } top_s;

   localparam logic [qenc_pkg::GATE_W-1:0] GATE_RELOAD = qenc_pkg::GATE_W'(SPEED_GATE_CYCLES - 1);
   localparam logic [2:0] SEL_CTRL   = 3'h0;
   localparam logic [2:0] SEL_FILTER = 3'h1;
   localparam logic [2:0] SEL_POS    = 3'h2;
   localparam logic [2:0] SEL_SPEED  = 3'h3;
   localparam logic [2:0] SEL_STATUS = 3'h4;
   localparam logic [2:0] SEL_NONE   = 3'h7;

   top_s                        st_reg;
   top_s                        st_next;
   logic [2:0]                  lv;
   logic                        sample_en;
   logic                        aw_take;
   logic                        w_take;
   logic                        ar_take;
   logic                        do_write;
   logic [qenc_pkg::ADDR_W-1:0] wr_addr;
   logic [31:0]                 wr_data;
   logic [3:0]                  wr_strb;
   logic [2:0]                  wr_sel;
   logic                        clr_cmd;
   logic                        ctrl_hi_wr;
   logic                        a_chg;
   logic                        b_chg;
   logic                        step;
   logic                        fwd;
   logic                        idx_rise;
   logic                        idx_clear;
   logic [31:0]                 delta;
   logic [9:0]                  filt_new;

   ////////////////////////////////////////////////////////////////////////////
   // address decode, shared by read and write paths
   function automatic logic [2:0] reg_sel(input logic [qenc_pkg::ADDR_W-1:0] addr);
      case (addr)
         qenc_pkg::OFF_CTRL:     reg_sel = SEL_CTRL;
         qenc_pkg::OFF_FILTER:   reg_sel = SEL_FILTER;
         qenc_pkg::OFF_POSITION: reg_sel = SEL_POS;
         qenc_pkg::OFF_SPEED:    reg_sel = SEL_SPEED;
         qenc_pkg::OFF_STATUS:   reg_sel = SEL_STATUS;
         default:                reg_sel = SEL_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // input conditioning
   qenc_sample_divider u_div (
      .clk        (REF_CLK),
      .rst        (RESET),
      .filt_delay (st_reg.filt_delay),
      .sample_en  (sample_en)
   );

   // index pin may float unused; it only matters while armed
   qenc_input_sampler u_smp (
      .clk        (REF_CLK),
      .rst        (RESET),
      .pin_raw    ({ENC_INDEX, ENC_B, ENC_A}),
      .sample_en  (sample_en),
      .filt_delay (st_reg.filt_delay),
      .level      (lv)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_next = st_reg;
      filt_new = 10'h000;

      // bus handshakes
      aw_take = S_AXI_AWVALID && !st_reg.aw_have && !st_reg.bvalid;
      w_take = S_AXI_WVALID && !st_reg.w_have && !st_reg.bvalid;
      ar_take = S_AXI_ARVALID && !st_reg.rvalid;
      wr_addr = st_reg.aw_have ? st_reg.aw_addr : S_AXI_AWADDR;
      wr_data = st_reg.w_have ? st_reg.w_data : S_AXI_WDATA;
      wr_strb = st_reg.w_have ? st_reg.w_strb : S_AXI_WSTRB;
      do_write = (st_reg.aw_have || aw_take) && (st_reg.w_have || w_take);
      wr_sel = reg_sel(wr_addr);
      clr_cmd = do_write && wr_sel == SEL_CTRL && wr_strb[1] && wr_data[qenc_pkg::CTRL_CLEAR_BIT];
      ctrl_hi_wr = do_write && wr_sel == SEL_CTRL && wr_strb[1];

      // decoder: one phase change per cycle is enough for 5 MHz at this clock
      a_chg = lv[0] ^ st_reg.a_prev;
      b_chg = lv[1] ^ st_reg.b_prev;
      if (st_reg.x4) begin
         step = a_chg ^ b_chg;
         fwd = lv[0] ^ st_reg.b_prev;
      end else begin
         step = a_chg && !b_chg;
         fwd = lv[0] ^ lv[1];
      end
      idx_rise = lv[2] && !st_reg.i_prev;
      idx_clear = st_reg.enable && st_reg.armed && idx_rise;
      st_next.a_prev = lv[0];
      st_next.b_prev = lv[1];
      st_next.i_prev = lv[2];

      if (clr_cmd) begin
         st_next.position = 32'h0000_0000;
      end else if (idx_clear) begin
         st_next.position = 32'h0000_0000;
      end else if (st_reg.enable && step) begin
         if (fwd ^ st_reg.invert) begin
            st_next.position = st_reg.position + 32'h0000_0001;
         end else begin
            st_next.position = st_reg.position - 32'h0000_0001;
         end
      end
      if (idx_clear) begin
         st_next.armed = 1'b0;
      end

      // speed over a fixed gate, scaled to counts per minute
      delta = st_reg.position - st_reg.snap;
      if (st_reg.gate == '0) begin
         st_next.gate = GATE_RELOAD;
         st_next.speed = 32'($signed(delta) * qenc_pkg::SPEED_SCALE);
         st_next.snap = st_reg.position;
      end else begin
         st_next.gate = st_reg.gate - 22'h00_0001;
      end
      // a cleared count must not look like a jump in speed
      if (clr_cmd || idx_clear) begin
         st_next.snap = 32'h0000_0000;
      end

      // write path
      if (aw_take) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = S_AXI_AWADDR;
      end
      if (w_take) begin
         st_next.w_have = 1'b1;
         st_next.w_data = S_AXI_WDATA;
         st_next.w_strb = S_AXI_WSTRB;
      end
      if (do_write) begin
         st_next.aw_have = 1'b0;
         st_next.w_have = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = (wr_sel == SEL_NONE) ? qenc_pkg::RESP_SLVERR : qenc_pkg::RESP_OKAY;
         if (wr_sel == SEL_CTRL && wr_strb[0]) begin
            st_next.enable = wr_data[qenc_pkg::CTRL_ENABLE_BIT];
            st_next.x4 = wr_data[qenc_pkg::CTRL_X4_BIT];
            st_next.invert = wr_data[qenc_pkg::CTRL_INVERT_BIT];
         end
         if (ctrl_hi_wr) begin
            // software arming wins over a coincident index
            st_next.armed = wr_data[qenc_pkg::CTRL_ARM_BIT];
         end
         if (wr_sel == SEL_FILTER && wr_strb[1:0] != 2'h0) begin
            filt_new[7:0] = wr_strb[0] ? wr_data[7:0] : st_reg.filt_delay[7:0];
            filt_new[9:8] = wr_strb[1] ? wr_data[9:8] : st_reg.filt_delay[9:8];
            // settings above the maximum are clamped
            if (int'(filt_new) > qenc_pkg::FILT_MAX) begin
               st_next.filt_delay = qenc_pkg::FILT_W'(qenc_pkg::FILT_MAX);
            end else begin
               st_next.filt_delay = filt_new;
            end
         end
      end
      if (st_reg.bvalid && S_AXI_BREADY) begin
         st_next.bvalid = 1'b0;
      end

      // read path
      if (st_reg.rvalid && S_AXI_RREADY) begin
         st_next.rvalid = 1'b0;
      end
      if (ar_take) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = qenc_pkg::RESP_OKAY;
         st_next.rdata = 32'h0000_0000;
         unique case (reg_sel(S_AXI_ARADDR))
            SEL_CTRL: begin
               st_next.rdata[qenc_pkg::CTRL_ENABLE_BIT] = st_reg.enable;
               st_next.rdata[qenc_pkg::CTRL_X4_BIT] = st_reg.x4;
               st_next.rdata[qenc_pkg::CTRL_INVERT_BIT] = st_reg.invert;
               st_next.rdata[qenc_pkg::CTRL_ARM_BIT] = st_reg.armed;
            end
            SEL_FILTER: begin
               st_next.rdata[9:0] = st_reg.filt_delay;
            end
            SEL_POS: begin
               st_next.rdata = st_reg.position;
            end
            SEL_SPEED: begin
               st_next.rdata = st_reg.speed;
            end
            SEL_STATUS: begin
               st_next.rdata[qenc_pkg::STAT_ARMED_BIT] = st_reg.armed;
               st_next.rdata[qenc_pkg::STAT_LEVEL_LSB +: 3] = lv;
               st_next.rdata[qenc_pkg::STAT_ENABLE_BIT] = st_reg.enable;
            end
            SEL_NONE: begin
               st_next.rresp = qenc_pkg::RESP_SLVERR;
            end
            default: begin
               st_next.rresp = qenc_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign S_AXI_AWREADY = !st_reg.aw_have && !st_reg.bvalid;
   assign S_AXI_WREADY = !st_reg.w_have && !st_reg.bvalid;
   assign S_AXI_BVALID = st_reg.bvalid;
   assign S_AXI_BRESP = st_reg.bresp;
   assign S_AXI_ARREADY = !st_reg.rvalid;
   assign S_AXI_RVALID = st_reg.rvalid;
   assign S_AXI_RDATA = st_reg.rdata;
   assign S_AXI_RRESP = st_reg.rresp;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   a_disabled_hold: assert property (
      !st_reg.enable && !clr_cmd |=> $stable(st_reg.position))
      else $error("count moved while disabled");

   a_x4_step: assert property (
      st_reg.enable && st_reg.x4 && (a_chg ^ b_chg) && !clr_cmd && !idx_clear
      |=> st_reg.position == $past(st_reg.position) + 32'h0000_0001
       || st_reg.position == $past(st_reg.position) - 32'h0000_0001)
      else $error("quadruple mode edge did not count by one");

   a_fwd_count: assert property (
      st_reg.enable && st_reg.x4 && !st_reg.invert && a_chg && !b_chg
      && (lv[0] ^ st_reg.b_prev) && !clr_cmd && !idx_clear
      |=> st_reg.position == $past(st_reg.position) + 32'h0000_0001)
      else $error("forward edge did not increment");

   a_invert_dir: assert property (
      st_reg.enable && st_reg.x4 && st_reg.invert && a_chg && !b_chg
      && (lv[0] ^ st_reg.b_prev) && !clr_cmd && !idx_clear
      |=> st_reg.position == $past(st_reg.position) - 32'h0000_0001)
      else $error("inverted forward edge did not decrement");

   a_x2_b_ignored: assert property (
      st_reg.enable && !st_reg.x4 && b_chg && !a_chg && !clr_cmd && !idx_clear
      |=> $stable(st_reg.position))
      else $error("double mode counted a phase b edge");

   a_x2_step: assert property (
      st_reg.enable && !st_reg.x4 && a_chg && !b_chg && !clr_cmd && !idx_clear
      |=> st_reg.position != $past(st_reg.position))
      else $error("double mode missed a phase a edge");

   a_soft_clear: assert property (
      clr_cmd |=> st_reg.position == 32'h0000_0000 && st_reg.snap == 32'h0000_0000)
      else $error("clear command did not zero the count");

   a_index_clear: assert property (
      idx_clear && !clr_cmd && !ctrl_hi_wr |=> st_reg.position == 32'h0000_0000 && !st_reg.armed)
      else $error("armed index did not clear and disarm");

   a_speed_scale: assert property (
      st_reg.gate == '0 |=> st_reg.speed == 32'($signed($past(st_reg.position - st_reg.snap))
                                             * qenc_pkg::SPEED_SCALE)
      ##1 $stable(st_reg.speed))
      else $error("speed not scaled to counts per minute");

endmodule
`default_nettype wire

// [qenc_enc_model.sv]
// behavioural incremental encoder driving phase and index pins
`timescale 1ns/10ps
`default_nettype none
module qenc_enc_model (
   // clock
   input  wire logic clk,
   // step request and index level
   input  wire logic step,
   input  wire logic fwd,
   input  wire logic idx_in,
   // encoder pins
   output logic      a,
   output logic      b,
   output logic      idx
);
   logic [1:0] ph = 2'h0;
   // one gray step per request, so both phases never move together
   always_ff @(posedge clk) begin
      if (step) begin
         ph <= fwd ? ph + 2'h1 : ph - 2'h1;
      end
   end
   // forward order ab 00,10,11,01
   assign a   = ph[0] ^ ph[1];
   assign b   = ph[1];
   assign idx = idx_in;
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the quadrature encoder counter
`timescale 1ns/10ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [2:0]  c;
      logic        f;
      logic [3:0]  n;
      logic [31:0] e;
   } row_s;
   row_s rows [6] = '{'{3'h3, 1'b1, 4'h6, 32'h00000006}, '{3'h3, 1'b0, 4'h5, 32'hfffffffb},
                      '{3'h7, 1'b1, 4'h4, 32'hfffffffc}, '{3'h1, 1'b1, 4'h8, 32'h00000004},
                      '{3'h1, 1'b0, 4'h4, 32'hfffffffe}, '{3'h2, 1'b1, 4'h4, 32'h00000000}};
   logic        ref_clk = 1'b0, reset = 1'b1, stp = 1'b0, fw = 1'b0, ix = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic [4:0]  awa = 5'h00, ara = 5'h00;
   logic [31:0] wd = 32'h0, d;
   logic [3:0]  wst = 4'h0;
   logic        enc_a, enc_b, enc_idx, awr, wr, bv, arr, rv;
   logic [1:0]  br, rr, r;
   logic [31:0] rd;
   int          n_fail = 0, total_checks = 0;

   always #2 ref_clk = ~ref_clk;

   qenc_enc_model enc (.clk(ref_clk), .step(stp), .fwd(fw), .idx_in(ix), .a(enc_a), .b(enc_b), .idx(enc_idx));
   quadrature_encoder_counter #(.SPEED_GATE_CYCLES(1000)) DUT (
      .REF_CLK(ref_clk), .RESET(reset), .ENC_A(enc_a), .ENC_B(enc_b), .ENC_INDEX(enc_idx),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(wst),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_BRESP(br),
      .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr));

   ////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic axw(input logic [4:0] a, input logic [31:0] v, output logic [1:0] p);
      logic dn;
      dn = 1'b0;
      @(posedge ref_clk);
      awv <= 1'b1;
      wv  <= 1'b1;
      awa <= a;
      wd  <= v;
      wst <= 4'hf;
      bre <= 1'b1;
      while (!dn) begin
         @(posedge ref_clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr) wv <= 1'b0;
         if (bv && bre) begin
            p = br;
            bre <= 1'b0;
            dn = 1'b1;
         end
      end
   endtask
   task automatic axr(input logic [4:0] a, output logic [31:0] q, output logic [1:0] p);
      logic dn;
      dn = 1'b0;
      @(posedge ref_clk);
      arv <= 1'b1;
      ara <= a;
      rre <= 1'b1;
      while (!dn) begin
         @(posedge ref_clk);
         if (arv && arr) arv <= 1'b0;
         if (rv && rre) begin
            q = rd;
            p = rr;
            rre <= 1'b0;
            dn = 1'b1;
         end
      end
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      logic [31:0] q;
      logic [1:0]  p;
      axr(a, q, p);
      chk(q, e);
   endtask
   // gap in clocks between steps; 50 is the fastest legal edge rate
   task automatic steps(input int n, input logic f, input int gap);
      repeat (n) begin
         @(posedge ref_clk);
         stp <= 1'b1;
         fw  <= f;
         @(posedge ref_clk);
         stp <= 1'b0;
         repeat (gap - 2) @(posedge ref_clk);
      end
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic ipulse;
      @(posedge ref_clk);
      ix <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ix <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic end_sim;
      if (n_fail == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      rdc(qenc_pkg::OFF_CTRL, 32'h0);
      rdc(qenc_pkg::OFF_FILTER, 32'h0);
      rdc(qenc_pkg::OFF_POSITION, 32'h0);
      // each row clears the count together with its control write
      foreach (rows[i]) begin
         axw(qenc_pkg::OFF_CTRL, {23'h0, 1'b1, 5'h0, rows[i].c}, r);
         steps(int'(rows[i].n), rows[i].f, 50);
         rdc(qenc_pkg::OFF_POSITION, rows[i].e);
      end
      // oversized delay clamps; the slow filter must hold back a fresh edge
      axw(qenc_pkg::OFF_FILTER, 32'h000003ff, r);
      rdc(qenc_pkg::OFF_FILTER, 32'h000003e8);
      axw(qenc_pkg::OFF_CTRL, 32'h00000103, r);
      steps(1, 1'b1, 50);
      rdc(qenc_pkg::OFF_POSITION, 32'h0);
      // two slow samples, 16000 clocks apart, let the edge through
      repeat (33000) @(posedge ref_clk);
      rdc(qenc_pkg::OFF_POSITION, 32'h1);
      axw(qenc_pkg::OFF_FILTER, 32'h0, r);
      steps(1, 1'b1, 50);
      rdc(qenc_pkg::OFF_POSITION, 32'h2);
      axw(qenc_pkg::OFF_CTRL, 32'h00000101, r);
      rdc(qenc_pkg::OFF_POSITION, 32'h0);
      // ten counts per gate gives 60000 counts per minute
      axw(qenc_pkg::OFF_CTRL, 32'h00000103, r);
      fork
         steps(40, 1'b1, 100);
         begin
            repeat (2500) @(posedge ref_clk);
            rdc(qenc_pkg::OFF_SPEED, 32'h0000ea60);
         end
      join
      axw(qenc_pkg::OFF_CTRL, 32'h00000301, r);
      axr(qenc_pkg::OFF_STATUS, d, r);
      chk({31'h0, d[0]}, 32'h1);
      steps(4, 1'b1, 50);
      ipulse();
      rdc(qenc_pkg::OFF_POSITION, 32'h0);
      axr(qenc_pkg::OFF_STATUS, d, r);
      chk({31'h0, d[0]}, 32'h0);
      steps(4, 1'b1, 50);
      ipulse();
      rdc(qenc_pkg::OFF_POSITION, 32'h2);
      // unmapped and read-only places
      axw(5'h14, 32'h1, r);
      chk({30'h0, r}, {30'h0, qenc_pkg::RESP_SLVERR});
      axr(5'h14, d, r);
      chk(d, 32'h0);
      chk({30'h0, r}, {30'h0, qenc_pkg::RESP_SLVERR});
      axw(qenc_pkg::OFF_POSITION, 32'h55, r);
      chk({30'h0, r}, {30'h0, qenc_pkg::RESP_OKAY});
      rdc(qenc_pkg::OFF_POSITION, 32'h2);
      // reset in mid-run, pins left away from zero
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      rdc(qenc_pkg::OFF_CTRL, 32'h0);
      rdc(qenc_pkg::OFF_FILTER, 32'h0);
      rdc(qenc_pkg::OFF_POSITION, 32'h0);
      end_sim();
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      n_fail++;
      end_sim();
   end
endmodule
`default_nettype wire
